/* File: trim_cfg_pkg.sv */
// constants for the trim and configuration register bank
// What this block does
// - status bits set on matched location, cleared erased
// - overwrite status bit uses inverted polarity
// - trim fields locked until keys 01,10,11 written
// - key at 11 allows unlimited field writes
// - only writing 00 relocks a key at 11
// - other key writes ignored, key reads 11
// - read-only bit writes ignored without bus error
// - endian bit loaded, 1 big, 0 little
// - program/erase disable bits block protected pages
// - oscillator trims loaded when enabled, then writable
// - channel disables loaded when load flag set
// - disabled channel pin becomes external interrupt input
// - reference trim loaded if enabled, else zero
// - reference power-down bit: 1 off, 0 on
// - core regulator trim loaded if enabled, else zero
// - io regulator trim loaded if enabled, else 00
// - io regulator power-down and bypass controls
// - window bounds loaded; size is difference times 512
// - protection enable and local-read enable status
package trim_cfg_pkg;
    // register indices; byte address is four times the index
    localparam logic [5:0] IDX_STATUS   = 6'h2E;
    localparam logic [5:0] IDX_OSC      = 6'h30;
    localparam logic [5:0] IDX_CHANNEL  = 6'h34;
    localparam logic [5:0] IDX_VREF     = 6'h36;
    localparam logic [5:0] IDX_CORE     = 6'h37;
    localparam logic [5:0] IDX_PROT     = 6'h38;
    localparam logic [5:0] IDX_IO       = 6'h3E;

    // key field positions
    localparam int KEY_WIDE_LSB   = 30;
    localparam int KEY_NARROW_LSB = 6;
    localparam int KEY_CHAN_LSB   = 0;

    // oscillator trim register fields
    localparam int OSC_COARSE_LSB = 0;
    localparam int OSC_TUNE_LSB   = 8;
    localparam int OSC_FINE_LSB   = 16;
    localparam int OSC_TEMP_LSB   = 24;

    // reference, regulator and channel fields
    localparam int VREF_PD_BIT    = 5;
    localparam int IO_PD_BIT      = 3;
    localparam int IO_BYP_BIT     = 2;
    localparam int CHAN_OFF_LSB   = 3;

    // protection window register fields
    localparam int PROT_EN_BIT    = 0;
    localparam int PROT_OVR_BIT   = 1;
    localparam int PROT_LREAD_BIT = 2;
    localparam int PROT_UPPER_LSB = 8;
    localparam int PROT_LOWER_LSB = 16;

    // status register bits
    localparam int ST_REF_TE      = 0;
    localparam int ST_IO_TE       = 1;
    localparam int ST_PROG_DIS    = 2;
    localparam int ST_ERASE_DIS   = 3;
    localparam int ST_ENDIAN      = 4;
    localparam int ST_OSC_TE      = 5;
    localparam int ST_CORE_TE     = 6;

    // key values and sizes
    localparam logic [1:0] KEY_STEP1  = 2'h1;
    localparam logic [1:0] KEY_STEP2  = 2'h2;
    localparam logic [1:0] KEY_OPEN   = 2'h3;
    localparam logic [1:0] KEY_LOCKED = 2'h0;
    localparam int         PAGE_SHIFT = 9;     // 512-byte pages

    typedef enum logic {LOAD_FILL, LOAD_DONE} load_state_t;
endpackage

/* File: trim_key_lock.sv */
// write-access key sequencer for one protected register
`timescale 1ns/1ps
module trim_key_lock (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       wr_en,
    input  wire logic [1:0] wr_key,
    output logic [1:0]      key,
    output logic            unlocked
);
    logic [1:0] next_key;

    // advance on the right step, restart on a wrong one
    always_comb begin
        next_key = key;
        if (wr_en) begin
            if (key == trim_cfg_pkg::KEY_OPEN) begin
                if (wr_key == trim_cfg_pkg::KEY_LOCKED) begin
                    next_key = trim_cfg_pkg::KEY_LOCKED;
                end else begin
                    next_key = trim_cfg_pkg::KEY_OPEN;
                end
            end else if (wr_key == trim_cfg_pkg::KEY_STEP1) begin
                next_key = trim_cfg_pkg::KEY_STEP1;
            end else if (wr_key == trim_cfg_pkg::KEY_STEP2 && key == trim_cfg_pkg::KEY_STEP1) begin
                next_key = trim_cfg_pkg::KEY_STEP2;
            end else if (wr_key == trim_cfg_pkg::KEY_OPEN && key == trim_cfg_pkg::KEY_STEP2) begin
                next_key = trim_cfg_pkg::KEY_OPEN;
            end else begin
                next_key = trim_cfg_pkg::KEY_LOCKED;
            end
        end
    end

    // key storage, locked after reset
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            key <= trim_cfg_pkg::KEY_LOCKED;
        end else begin
            key <= next_key;
        end
    end

    assign unlocked = (key == trim_cfg_pkg::KEY_OPEN);
endmodule // trim_key_lock

/* File: trim_config_register_set.sv */
// power-on loaded trim and configuration register bank with apb access
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module trim_config_register_set (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // information-area contents seen at power-on
    input  wire logic [6:0]  info_status_match,
    input  wire logic        info_prot_en_match,
    input  wire logic        info_prot_ovr_match,
    input  wire logic        info_prot_lread_match,
    input  wire logic [6:0]  info_upper_page,
    input  wire logic [6:0]  info_lower_page,
    input  wire logic [1:0]  info_osc_coarse,
    input  wire logic [4:0]  info_osc_tune,
    input  wire logic [6:0]  info_osc_fine,
    input  wire logic [2:0]  info_osc_temp,
    input  wire logic [4:0]  info_reference_trim,
    input  wire logic [5:0]  info_core_trim,
    input  wire logic [1:0]  info_io_trim,
    input  wire logic        analog_cfg_poweron_load,
    input  wire logic [4:0]  info_channel_off,
    // flash requests aimed at protection configuration pages
    input  wire logic        prot_page_program_req,
    input  wire logic        prot_page_erase_req,
    // controls to analog and system
    output logic [1:0]       osc_coarse_trim,
    output logic [4:0]       osc_coarse_tune_trim,
    output logic [6:0]       osc_fine_trim,
    output logic [2:0]       osc_temp_trim,
    output logic [4:0]       reference_trim_value,
    output logic             reference_power_down,
    output logic [5:0]       core_regulator_trim_value,
    output logic [1:0]       io_regulator_trim_value,
    output logic             io_regulator_power_down,
    output logic             io_regulator_bypass,
    output logic [7:3]       analog_channel_off_bits,
    output logic [7:3]       analog_input_pin_enable,
    output logic [7:3]       external_irq_pin_enable,
    output logic             cpu_big_endian,
    output logic             protection_enabled,
    output logic             protected_local_read_enable,
    output logic [6:0]       protected_upper_page,
    output logic [6:0]       protected_lower_page,
    output logic [15:0]      prot_window_bytes,
    output logic             prot_program_allow,
    output logic             prot_erase_allow
);
    trim_cfg_pkg::load_state_t load_state;

    logic [6:0] status;
    logic       protection_cfg_overwritten;

    // status register bit aliases
    wire prot_area_program_disable  = status[trim_cfg_pkg::ST_PROG_DIS];
    wire prot_area_erase_disable    = status[trim_cfg_pkg::ST_ERASE_DIS];

    // apb decode; the write lands on the edge where pready is seen high
    wire        addr_hi_zero = (paddr[11:8] == 4'h0);
    wire [5:0]  idx          = paddr[7:2];
    wire        sel_status   = addr_hi_zero && idx == trim_cfg_pkg::IDX_STATUS;
    wire        sel_osc      = addr_hi_zero && idx == trim_cfg_pkg::IDX_OSC;
    wire        sel_channel  = addr_hi_zero && idx == trim_cfg_pkg::IDX_CHANNEL;
    wire        sel_vref     = addr_hi_zero && idx == trim_cfg_pkg::IDX_VREF;
    wire        sel_core     = addr_hi_zero && idx == trim_cfg_pkg::IDX_CORE;
    wire        sel_prot     = addr_hi_zero && idx == trim_cfg_pkg::IDX_PROT;
    wire        sel_io       = addr_hi_zero && idx == trim_cfg_pkg::IDX_IO;
    wire        mapped       = sel_status | sel_osc | sel_channel | sel_vref
                             | sel_core | sel_prot | sel_io;
    wire        ready_state  = (load_state == trim_cfg_pkg::LOAD_DONE);
    wire        answer_now   = psel & penable & ~pready & ready_state;
    wire        wr_fire      = psel & penable & pready & pwrite;
    wire        loading      = (load_state == trim_cfg_pkg::LOAD_FILL);

    // key field views of the write data
    wire [1:0]  wide_key     = pwdata[trim_cfg_pkg::KEY_WIDE_LSB +: 2];
    wire [1:0]  narrow_key   = pwdata[trim_cfg_pkg::KEY_NARROW_LSB +: 2];
    wire [1:0]  chan_key     = pwdata[trim_cfg_pkg::KEY_CHAN_LSB +: 2];

    wire [1:0]  osc_key;
    wire [1:0]  vref_key;
    wire [1:0]  core_key;
    wire [1:0]  io_key;
    wire [1:0]  chan_key_q;
    wire        osc_open;
    wire        vref_open;
    wire        core_open;
    wire        io_open;
    wire        chan_open;

    // one key sequencer per protected register
    trim_key_lock u_osc_key (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .wr_en    (wr_fire & sel_osc),
        .wr_key   (wide_key),
        .key      (osc_key),
        .unlocked (osc_open)
    );
    trim_key_lock u_vref_key (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .wr_en    (wr_fire & sel_vref),
        .wr_key   (narrow_key),
        .key      (vref_key),
        .unlocked (vref_open)
    );
    trim_key_lock u_core_key (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .wr_en    (wr_fire & sel_core),
        .wr_key   (narrow_key),
        .key      (core_key),
        .unlocked (core_open)
    );
    trim_key_lock u_io_key (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .wr_en    (wr_fire & sel_io),
        .wr_key   (narrow_key),
        .key      (io_key),
        .unlocked (io_open)
    );
    trim_key_lock u_chan_key (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .wr_en    (wr_fire & sel_channel),
        .wr_key   (chan_key),
        .key      (chan_key_q),
        .unlocked (chan_open)
    );

    // field writes only while the key already stood at open
    wire osc_wr  = wr_fire & sel_osc & osc_open;
    wire vref_wr = wr_fire & sel_vref & vref_open;
    wire core_wr = wr_fire & sel_core & core_open;
    wire io_wr   = wr_fire & sel_io & io_open;
    wire chan_wr = wr_fire & sel_channel & chan_open;

    // register images for read back; unused bits read zero
    wire [31:0] img_status = {25'h0000000, status};
    wire [31:0] img_osc    = {osc_key, 3'h0, osc_temp_trim, 1'h0, osc_fine_trim,
                              3'h0, osc_coarse_tune_trim, 6'h00, osc_coarse_trim};
    wire [31:0] img_vref   = {24'h000000, vref_key, reference_power_down,
                              reference_trim_value};
    wire [31:0] img_core   = {24'h000000, core_key, core_regulator_trim_value};
    wire [31:0] img_io     = {24'h000000, io_key, 2'h0, io_regulator_power_down,
                              io_regulator_bypass, io_regulator_trim_value};
    wire [31:0] img_chan   = {24'h000000, analog_channel_off_bits, 1'h0, chan_key_q};
    wire [31:0] img_prot   = {9'h000, protected_lower_page, 1'h0, protected_upper_page,
                              5'h00, protected_local_read_enable,
                              protection_cfg_overwritten, protection_enabled};
    wire [31:0] read_mux   = sel_status  ? img_status :
                             sel_osc     ? img_osc    :
                             sel_vref    ? img_vref   :
                             sel_core    ? img_core   :
                             sel_io      ? img_io     :
                             sel_channel ? img_chan   :
                             sel_prot    ? img_prot   : 32'h00000000;

    // window size in bytes from the page bounds
    wire [6:0]  page_span  = protected_upper_page - protected_lower_page;
    wire [15:0] next_size  = {page_span, 9'h000};

    // one-cycle power-on load after reset release
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            load_state <= trim_cfg_pkg::LOAD_FILL;
        end else begin
            load_state <= trim_cfg_pkg::LOAD_DONE;
        end
    end

    // apb answer: one wait state, error only on unmapped addresses
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= answer_now;
            pslverr <= answer_now & ~mapped;
            if (answer_now) begin
                prdata <= read_mux;
            end
        end
    end

    // factory status captured from the information area
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            status                      <= 7'h00;
            protection_enabled          <= 1'b0;
            protection_cfg_overwritten  <= 1'b0;
            protected_local_read_enable <= 1'b0;
            protected_upper_page        <= 7'h00;
            protected_lower_page        <= 7'h00;
        end else if (loading) begin
            status                      <= info_status_match;
            protection_enabled          <= info_prot_en_match;
            protection_cfg_overwritten  <= ~info_prot_ovr_match;
            protected_local_read_enable <= info_prot_lread_match;
            protected_upper_page        <= info_upper_page;
            protected_lower_page        <= info_lower_page;
        end
    end

    // oscillator trims: load when trimmed, then software writable
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            osc_coarse_trim      <= 2'h0;
            osc_coarse_tune_trim <= 5'h00;
            osc_fine_trim        <= 7'h00;
            osc_temp_trim        <= 3'h0;
        end else if (loading && info_status_match[trim_cfg_pkg::ST_OSC_TE]) begin
            osc_coarse_trim      <= info_osc_coarse;
            osc_coarse_tune_trim <= info_osc_tune;
            osc_fine_trim        <= info_osc_fine;
            osc_temp_trim        <= info_osc_temp;
        end else if (osc_wr) begin
            osc_coarse_trim      <= pwdata[trim_cfg_pkg::OSC_COARSE_LSB +: 2];
            osc_coarse_tune_trim <= pwdata[trim_cfg_pkg::OSC_TUNE_LSB +: 5];
            osc_fine_trim        <= pwdata[trim_cfg_pkg::OSC_FINE_LSB +: 7];
            osc_temp_trim        <= pwdata[trim_cfg_pkg::OSC_TEMP_LSB +: 3];
        end
    end

    // reference trim and power-down
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            reference_trim_value <= 5'h00;
            reference_power_down <= 1'b0;
        end else if (loading) begin
            if (info_status_match[trim_cfg_pkg::ST_REF_TE]) begin
                reference_trim_value <= info_reference_trim;
            end
        end else if (vref_wr) begin
            reference_trim_value <= pwdata[4:0];
            reference_power_down <= pwdata[trim_cfg_pkg::VREF_PD_BIT];
        end
    end

    // core regulator trim
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            core_regulator_trim_value <= 6'h00;
        end else if (loading) begin
            if (info_status_match[trim_cfg_pkg::ST_CORE_TE]) begin
                core_regulator_trim_value <= info_core_trim;
            end
        end else if (core_wr) begin
            core_regulator_trim_value <= pwdata[5:0];
        end
    end

    // io regulator trim, power-down and bypass
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            io_regulator_trim_value <= 2'h0;
            io_regulator_power_down <= 1'b0;
            io_regulator_bypass     <= 1'b0;
        end else if (loading) begin
            if (info_status_match[trim_cfg_pkg::ST_IO_TE]) begin
                io_regulator_trim_value <= info_io_trim;
            end
        end else if (io_wr) begin
            io_regulator_trim_value <= pwdata[1:0];
            io_regulator_power_down <= pwdata[trim_cfg_pkg::IO_PD_BIT];
            io_regulator_bypass     <= pwdata[trim_cfg_pkg::IO_BYP_BIT];
        end
    end

    // analog channel disables and pin routing
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            analog_channel_off_bits <= 5'h00;
            analog_input_pin_enable <= 5'h00;
            external_irq_pin_enable <= 5'h00;
        end else begin
            if (loading && analog_cfg_poweron_load) begin
                analog_channel_off_bits <= info_channel_off;
            end else if (chan_wr) begin
                analog_channel_off_bits <= pwdata[trim_cfg_pkg::CHAN_OFF_LSB +: 5];
            end
            analog_input_pin_enable <= ~analog_channel_off_bits;
            external_irq_pin_enable <= analog_channel_off_bits;
        end
    end

    // system outputs derived from the status, the page bounds and the flash requests
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cpu_big_endian     <= 1'b0;
            prot_window_bytes  <= 16'h0000;
            prot_program_allow <= 1'b0;
            prot_erase_allow   <= 1'b0;
        end else begin
            cpu_big_endian     <= status[trim_cfg_pkg::ST_ENDIAN];
            prot_window_bytes  <= next_size;
            prot_program_allow <= prot_page_program_req & ~prot_area_program_disable;
            prot_erase_allow   <= prot_page_erase_req & ~prot_area_erase_disable;
        end
    end
endmodule // trim_config_register_set

/* File: trim_config_register_set_sva.sv */
// concurrent checks on the ports of the trim and configuration register bank
`timescale 1ns/1ps
module trim_config_register_set_sva (
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [11:0] paddr,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        prot_page_program_req,
    input wire logic        prot_page_erase_req,
    input wire logic        prot_program_allow,
    input wire logic        prot_erase_allow,
    input wire logic [7:3]  analog_channel_off_bits,
    input wire logic [7:3]  analog_input_pin_enable,
    input wire logic [7:3]  external_irq_pin_enable,
    input wire logic [6:0]  protected_upper_page,
    input wire logic [6:0]  protected_lower_page,
    input wire logic [15:0] prot_window_bytes,
    input wire logic        cpu_big_endian,
    input wire logic        protection_enabled,
    input wire logic        protected_local_read_enable
);
    // decode of the word addresses that hold a register
    wire mapped = paddr[11:8] == 4'h0 && paddr[7:2] inside {trim_cfg_pkg::IDX_STATUS,
        trim_cfg_pkg::IDX_OSC, trim_cfg_pkg::IDX_CHANNEL, trim_cfg_pkg::IDX_VREF,
        trim_cfg_pkg::IDX_CORE, trim_cfg_pkg::IDX_PROT, trim_cfg_pkg::IDX_IO};

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    // access phase waiting for its answer, then a one-cycle answer
    sequence s_access; psel && penable && !pready; endsequence
    sequence s_answer; pready ##1 !pready; endsequence

    property p_answer; s_access |=> s_answer; endproperty
    a_answer: assert property (p_answer) else $error("access not answered after one wait");
    property p_idle; !(psel && penable) |=> !pready; endproperty
    a_idle: assert property (p_idle) else $error("answer without an access phase");
    property p_err; pready |-> pslverr == !mapped; endproperty
    a_err: assert property (p_err) else $error("error response wrong for address");
    property p_prog; prot_program_allow |-> $past(prot_page_program_req); endproperty
    a_prog: assert property (p_prog) else $error("program allowed without request");
    property p_erase; prot_erase_allow |-> $past(prot_page_erase_req); endproperty
    a_erase: assert property (p_erase) else $error("erase allowed without request");
    property p_pins;
        !$past(sys_rst) |-> external_irq_pin_enable == $past(analog_channel_off_bits)
            && analog_input_pin_enable == ~$past(analog_channel_off_bits);
    endproperty
    a_pins: assert property (p_pins) else $error("pin routing does not follow disables");
    property p_window;
        !$past(sys_rst) |-> prot_window_bytes ==
            {$past(protected_upper_page) - $past(protected_lower_page), 9'h000};
    endproperty
    a_window: assert property (p_window) else $error("window size wrong");
    property p_stat;
        !$past(sys_rst) && !$past(sys_rst, 2) && !$past(sys_rst, 3) |-> $stable({cpu_big_endian,
            protection_enabled, protected_local_read_enable, protected_upper_page});
    endproperty
    a_stat: assert property (p_stat) else $error("loaded status changed after load");
endmodule // trim_config_register_set_sva

bind trim_config_register_set trim_config_register_set_sva chk (.*);

/* File: trim_config_register_set_bench.sv */
// self-checking bench for the trim and configuration register bank
`timescale 1ns/1ps
module trim_config_register_set_bench;
    logic clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata;
    logic pready, pslverr, prot_page_program_req = 0, prot_page_erase_req = 0;
    logic [6:0] info_status_match = 7'h75, info_upper_page = 7'h50, info_lower_page = 7'h10;
    logic info_prot_en_match = 1, info_prot_ovr_match = 1, info_prot_lread_match = 0;
    logic [1:0] info_osc_coarse = 2'h2, info_io_trim = 2'h3, osc_coarse_trim, io_regulator_trim_value;
    logic [4:0] info_osc_tune = 5'h15, info_reference_trim = 5'h13, info_channel_off = 5'h16;
    logic [6:0] info_osc_fine = 7'h5A, osc_fine_trim, protected_upper_page, protected_lower_page;
    logic [2:0] info_osc_temp = 3'h5, osc_temp_trim;
    logic [5:0] info_core_trim = 6'h2D, core_regulator_trim_value;
    logic [4:0] osc_coarse_tune_trim, reference_trim_value;
    logic analog_cfg_poweron_load = 1, reference_power_down, io_regulator_power_down;
    logic io_regulator_bypass, cpu_big_endian, protection_enabled, protected_local_read_enable;
    logic prot_program_allow, prot_erase_allow;
    logic [7:3] analog_channel_off_bits, analog_input_pin_enable, external_irq_pin_enable;
    logic [15:0] prot_window_bytes;
    int n_mismatch = 0, samples_checked = 0;

    trim_config_register_set uut (.*);

    // 40 MHz clock
    initial forever #12.5 clk = ~clk;

    task automatic end_of_test;
        $display("mismatches %0d, comparisons %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one apb transfer; setup, access held until pready, then one idle edge
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        input logic [31:0] exp_r, input logic exp_e);
        int n;
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1;
        n = 0;
        do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin n_mismatch++; end_of_test; end
        chk(pslverr, exp_e);
        if (!w) chk(prdata, exp_r);
        psel <= 0; penable <= 0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d); xfer(1, a, d, 0, 0); endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e); xfer(0, a, 0, e, 0); endtask

    task automatic unlock(input logic [11:0] a, input int k);
        wr(a, 32'h1 << k); wr(a, 32'h2 << k); wr(a, 32'h3 << k);
    endtask

    // power-on load of every register and the derived outputs
    task automatic t_load;
        rd(12'hB8, 32'h0000_0075);
        rd(12'hC0, 32'h055A_1502);
        rd(12'hD8, 32'h0000_0013);
        rd(12'hDC, 32'h0000_002D);
        rd(12'hF8, 32'h0000_0000);
        rd(12'hD0, 32'h0000_00B0);
        rd(12'hE0, 32'h0010_5001);
        chk(cpu_big_endian, 1);
        chk(prot_window_bytes, 32'h8000);
        chk({protection_enabled, protected_local_read_enable, protected_upper_page,
             protected_lower_page, analog_channel_off_bits}, 32'h15_0216);
        $display("t_load done");
    endtask

    // key sequence on the reference register: wrong order, unlock, writes, relock
    task automatic t_keys;
        wr(12'hD8, 32'h1F); rd(12'hD8, 32'h13);
        wr(12'hD8, 32'h80); wr(12'hD8, 32'hC0); wr(12'hD8, 32'h1F); rd(12'hD8, 32'h13);
        unlock(12'hD8, 6); rd(12'hD8, 32'hD3);
        wr(12'hD8, 32'hEA); rd(12'hD8, 32'hEA);
        chk({reference_power_down, reference_trim_value}, 32'h2A);
        wr(12'hD8, 32'h85); rd(12'hD8, 32'hC5);
        chk(reference_power_down, 0);
        wr(12'hD8, 32'h01); rd(12'hD8, 32'h01);
        wr(12'hD8, 32'h1F); rd(12'hD8, 32'h01);
        $display("t_keys done");
    endtask

    // unlock each other protected register and write every bit
    task automatic t_open_all;
        unlock(12'hC0, 30); wr(12'hC0, 32'hFFFF_FFFF); rd(12'hC0, 32'hC77F_1F03);
        chk({osc_temp_trim, osc_fine_trim, osc_coarse_tune_trim, osc_coarse_trim}, 32'h1FFFF);
        unlock(12'hDC, 6); wr(12'hDC, 32'hFF); rd(12'hDC, 32'hFF);
        chk(core_regulator_trim_value, 32'h3F);
        unlock(12'hF8, 6); wr(12'hF8, 32'hFF); rd(12'hF8, 32'hCF);
        chk({io_regulator_power_down, io_regulator_bypass, io_regulator_trim_value}, 32'hF);
        unlock(12'hD0, 0); wr(12'hD0, 32'hFF); rd(12'hD0, 32'hFB);
        chk({external_irq_pin_enable, analog_input_pin_enable}, 32'h3E0);
        $display("t_open_all done");
    endtask

    // read-only writes ignored without error, unmapped places refused
    task automatic t_ro;
        wr(12'hB8, 32'hFFFF_FFFF); rd(12'hB8, 32'h75);
        wr(12'hE0, 32'hFFFF_FFFF); rd(12'hE0, 32'h0010_5001);
        xfer(0, 12'h100, 0, 0, 1);
        xfer(1, 12'h004, 32'hFFFF_FFFF, 0, 1);
        $display("t_ro done");
    endtask

    // program disabled and erase enabled by the loaded status
    task automatic t_flash;
        prot_page_program_req <= 1; prot_page_erase_req <= 1;
        repeat (2) @(posedge clk);
        chk({prot_program_allow, prot_erase_allow}, 32'h1);
        $display("t_flash done");
    endtask

    // second reset with an erased information area
    task automatic t_reload;
        logic [11:0] a[6] = '{12'hB8, 12'hC0, 12'hD8, 12'hDC, 12'hF8, 12'hD0};
        sys_rst <= 1; info_status_match <= 0; analog_cfg_poweron_load <= 0;
        info_prot_en_match <= 0; info_prot_ovr_match <= 0; info_prot_lread_match <= 1;
        repeat (16) @(posedge clk);
        sys_rst <= 0;
        repeat (3) @(posedge clk);
        foreach (a[i]) rd(a[i], 0);
        rd(12'hE0, 32'h0010_5006);
        chk({cpu_big_endian, prot_program_allow, prot_erase_allow}, 32'h3);
        $display("t_reload done");
    endtask

    // main sequence
    initial begin
        repeat (16) @(posedge clk);
        sys_rst <= 0;
        repeat (3) @(posedge clk);
        t_load;
        t_keys;
        t_open_all;
        t_ro;
        t_flash;
        t_reload;
        end_of_test;
    end
endmodule // trim_config_register_set_bench
